// *** src/dsm_pkg.sv ***
// Package for the descriptor schedule map bank: offsets, reset values,
// slot geometry and the carrier structs shared by the bank and the scanner.
// Assumes one 10 MHz clock and a synchronous active-low reset everywhere.
package dsm_pkg;

  // Slot geometry
  localparam int          NUM_SLOTS  = 32;
  localparam int          SLOT_W     = 5;
  localparam int          DATA_W     = 32;
  localparam int          ADDR_W     = 16;
  localparam logic [4:0]  SLOT_FIRST = 5'h00;
  localparam logic [4:0]  SLOT_LAST  = 5'h1F;
  localparam logic [4:0]  SLOT_ONE   = 5'h01;

  // Register byte addresses
  localparam logic [15:0] OFF_ISO_FINAL   = 16'h0138;
  localparam logic [15:0] OFF_INT_DONE    = 16'h0140;
  localparam logic [15:0] OFF_INT_SKIP    = 16'h0144;
  localparam logic [15:0] OFF_INT_FINAL   = 16'h0148;
  localparam logic [15:0] OFF_ASYNC_DONE  = 16'h0150;
  localparam logic [15:0] OFF_ASYNC_SKIP  = 16'h0154;
  localparam logic [15:0] OFF_ASYNC_FINAL = 16'h0158;

  // Reset values
  localparam logic [31:0] RST_DONE  = 32'h0000_0000;
  localparam logic [31:0] RST_SKIP  = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_FINAL = 32'h0000_0000;
  localparam logic [31:0] RD_NONE   = 32'h0000_0000;
  localparam logic [31:0] NO_SKIP   = 32'h0000_0000;

  // One register access from the processor interface
  typedef struct packed {
    logic        rd;    // Read strobe, one cycle
    logic        wr;    // Write strobe, one cycle
    logic [15:0] addr;  // Byte address
    logic [31:0] wdata; // Write data
  } dsm_req_t;

  // Scanner answer: slot under examination and whether to process it
  typedef struct packed {
    logic [4:0]  slot;    // Current slot index
    logic        process; // Slot not skipped
    logic        wrap;    // Next step returns to slot zero
  } dsm_scan_t;

  // Address match for a one-word register
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    return addr == off;
  endfunction

endpackage

// *** src/dsm_slot_scan.sv ***
// Slot scanner for one descriptor category: walks slots in order,
// flags skipped slots and wraps after the final slot.
// Assumes the scan engine pulses step_i once it is done with a slot.
`timescale 1ns/10ps
module dsm_slot_scan
  import dsm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Engine handshake
  input  wire logic        step_i,
  input  wire logic        restart_i,
  // Map inputs
  input  wire logic [31:0] skip_map_i,
  input  wire logic [31:0] final_map_i,
  // Scan answer
  output dsm_scan_t        scan_o
);

  logic [4:0] slot;       // Slot under examination
  logic [4:0] next_slot;  // Slot for the next step
  wire        at_final;   // Current slot carries the final bit
  wire        at_top;     // Current slot is the highest one

  // Final bit is a one-hot position; no bit set means all 32 slots
  assign at_final = final_map_i[slot];
  assign at_top   = (slot == SLOT_LAST);

  // Order is plain slot order; a skipped slot's pointer is never read,
  // so it cannot redirect the walk
  assign next_slot = (at_final || at_top) ? SLOT_FIRST
                                          : slot + SLOT_ONE;

  // Slot register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || restart_i) begin
      slot <= SLOT_FIRST;
    end else if (step_i) begin
      slot <= next_slot;
    end
  end

  // A skipped slot is offered but never processed, valid flag or not
  assign scan_o.slot    = slot;
  assign scan_o.process = ~skip_map_i[slot];
  assign scan_o.wrap    = at_final || at_top;

endmodule // dsm_slot_scan

// *** src/dsm_sched_maps.sv ***
// Descriptor schedule map bank: completion, skip and final-slot maps for
// the interrupt and async lists, the isochronous final-slot map, and one
// slot scanner per category.
// Assumes single-cycle read and write strobes on the same clock, and
// completion pulses from the transfer engine on the same clock.
`timescale 1ns/10ps
module dsm_sched_maps
  import dsm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Processor register access
  input  dsm_req_t         req_i,
  output logic [31:0]      rdata_o,
  output logic             rvalid_o,
  // Completion events, one bit per slot, one-cycle pulses
  input  wire logic [31:0] int_done_i,
  input  wire logic [31:0] async_done_i,
  // Isochronous skip map, held in a neighbouring register
  input  wire logic [31:0] iso_skip_map_i,
  // Scan engine steps per category
  input  wire logic        iso_step_i,
  input  wire logic        int_step_i,
  input  wire logic        async_step_i,
  input  wire logic        scan_restart_i,
  // Scan answers per category
  output dsm_scan_t        iso_scan_o,
  output dsm_scan_t        int_scan_o,
  output dsm_scan_t        async_scan_o
);

  // Map registers
  logic [31:0] iso_final_slot_map;       // Isochronous final slot
  logic [31:0] interrupt_completion_map; // Interrupt completions
  logic [31:0] interrupt_skip_map;       // Interrupt skips
  logic [31:0] interrupt_final_slot_map; // Interrupt final slot
  logic [31:0] async_completion_map;     // Async completions
  logic [31:0] async_skip_map;           // Async skips
  logic [31:0] async_final_slot_map;     // Async final slot

  // Next values of the completion maps
  logic [31:0] next_int_done;
  logic [31:0] next_async_done;

  // Address decode
  wire sel_iso_final   = hit(req_i.addr, OFF_ISO_FINAL);
  wire sel_int_done    = hit(req_i.addr, OFF_INT_DONE);
  wire sel_int_skip    = hit(req_i.addr, OFF_INT_SKIP);
  wire sel_int_final   = hit(req_i.addr, OFF_INT_FINAL);
  wire sel_async_done  = hit(req_i.addr, OFF_ASYNC_DONE);
  wire sel_async_skip  = hit(req_i.addr, OFF_ASYNC_SKIP);
  wire sel_async_final = hit(req_i.addr, OFF_ASYNC_FINAL);

  // Clearing reads of the completion maps
  wire rd_int_done   = req_i.rd && sel_int_done;
  wire rd_async_done = req_i.rd && sel_async_done;

  // Writes; completion maps have no write strobe at all
  wire wr_iso_final   = req_i.wr && sel_iso_final;
  wire wr_int_skip    = req_i.wr && sel_int_skip;
  wire wr_int_final   = req_i.wr && sel_int_final;
  wire wr_async_skip  = req_i.wr && sel_async_skip;
  wire wr_async_final = req_i.wr && sel_async_final;

  // Read mux; unmapped addresses read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RD_NONE;
    if (sel_iso_final) begin
      rd_mux = iso_final_slot_map;
    end else if (sel_int_done) begin
      rd_mux = interrupt_completion_map;
    end else if (sel_int_skip) begin
      rd_mux = interrupt_skip_map;
    end else if (sel_int_final) begin
      rd_mux = interrupt_final_slot_map;
    end else if (sel_async_done) begin
      rd_mux = async_completion_map;
    end else if (sel_async_skip) begin
      rd_mux = async_skip_map;
    end else if (sel_async_final) begin
      rd_mux = async_final_slot_map;
    end
  end

  // Completion next values: a read clears only the bits it returned,
  // and a completion in the same cycle sets its bit after the clear,
  // so no event slips between two reads
  assign next_int_done =
    (interrupt_completion_map & ~(rd_int_done ? interrupt_completion_map : RD_NONE))
    | int_done_i;
  assign next_async_done =
    (async_completion_map & ~(rd_async_done ? async_completion_map : RD_NONE))
    | async_done_i;

  // Completion maps: software cannot write them
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      interrupt_completion_map <= RST_DONE;
      async_completion_map     <= RST_DONE;
    end else begin
      interrupt_completion_map <= next_int_done;
      async_completion_map     <= next_async_done;
    end
  end

  // Skip maps: every slot skipped until software says otherwise
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      interrupt_skip_map <= RST_SKIP;
      async_skip_map     <= RST_SKIP;
    end else begin
      if (wr_int_skip) begin
        interrupt_skip_map <= req_i.wdata;
      end
      if (wr_async_skip) begin
        async_skip_map <= req_i.wdata;
      end
    end
  end

  // Final-slot maps: zero means the whole 32-slot range is scanned
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      iso_final_slot_map       <= RST_FINAL;
      interrupt_final_slot_map <= RST_FINAL;
      async_final_slot_map     <= RST_FINAL;
    end else begin
      if (wr_iso_final) begin
        iso_final_slot_map <= req_i.wdata;
      end
      if (wr_int_final) begin
        interrupt_final_slot_map <= req_i.wdata;
      end
      if (wr_async_final) begin
        async_final_slot_map <= req_i.wdata;
      end
    end
  end

  // Read data register; it holds the pre-clear value of a completion map
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o  <= RD_NONE;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= rd_mux;
      end
    end
  end

  // Isochronous scanner; its skip map sits outside this bank
  dsm_slot_scan u_iso_scan (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .step_i      (iso_step_i),
    .restart_i   (scan_restart_i),
    .skip_map_i  (iso_skip_map_i),
    .final_map_i (iso_final_slot_map),
    .scan_o      (iso_scan_o)
  );

  // Interrupt scanner; same one-hot final reading as the others
  dsm_slot_scan u_int_scan (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .step_i      (int_step_i),
    .restart_i   (scan_restart_i),
    .skip_map_i  (interrupt_skip_map),
    .final_map_i (interrupt_final_slot_map),
    .scan_o      (int_scan_o)
  );

  // Async scanner
  dsm_slot_scan u_async_scan (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .step_i      (async_step_i),
    .restart_i   (scan_restart_i),
    .skip_map_i  (async_skip_map),
    .final_map_i (async_final_slot_map),
    .scan_o      (async_scan_o)
  );

endmodule // dsm_sched_maps

// *** tb/dsm_sched_maps_chk.sv ***
// Checker for the schedule map bank: read answers, completion maps, scanners.
// Sees only the top-level ports; bound to every bank instance below.
`timescale 1ns/10ps
module dsm_sched_maps_chk
  import dsm_pkg::*;
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // Register side
  input dsm_req_t         req_i,
  input wire logic [31:0] rdata_o,
  input wire logic        rvalid_o,
  // Events and scanners
  input wire logic [31:0] int_done_i,
  input wire logic [31:0] async_done_i,
  input wire logic [31:0] iso_skip_map_i,
  input wire logic        int_step_i,
  input wire logic        async_step_i,
  input wire logic        scan_restart_i,
  input dsm_scan_t        iso_scan_o,
  input dsm_scan_t        int_scan_o,
  input dsm_scan_t        async_scan_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Clearing reads of each completion map
  wire logic rd_int = req_i.rd && req_i.addr == OFF_INT_DONE;
  wire logic rd_as  = req_i.rd && req_i.addr == OFF_ASYNC_DONE;
  property p_rvalid; req_i.rd |=> rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  // Done pulse, idle cycle, then read: the pulse must show
  property p_done_set; int_done_i != 32'h0 ##2 rd_int
    |=> (rdata_o & $past(int_done_i, 3)) == $past(int_done_i, 3); endproperty
  a_done_set: assert property (p_done_set) else $error("done bit lost");
  property p_clear; rd_int && int_done_i == 32'h0 ##1 int_done_i == 32'h0
    ##1 rd_int && int_done_i == 32'h0 |=> rdata_o == RD_NONE; endproperty
  a_clear: assert property (p_clear) else $error("map not cleared");
  // A pulse on the clearing read survives to the next read
  property p_keep; rd_as && async_done_i != 32'h0 ##2 rd_as
    |=> (rdata_o & $past(async_done_i, 3)) == $past(async_done_i, 3); endproperty
  a_keep: assert property (p_keep) else $error("coincident done lost");
  property p_iso_proc; iso_scan_o.process == !iso_skip_map_i[iso_scan_o.slot]; endproperty
  a_iso_proc: assert property (p_iso_proc) else $error("skip ignored");
  property p_int_adv; int_step_i && !scan_restart_i && !int_scan_o.wrap
    |=> int_scan_o.slot == $past(int_scan_o.slot) + SLOT_ONE; endproperty
  a_int_adv: assert property (p_int_adv) else $error("slot not advanced");
  property p_as_wrap; async_step_i && async_scan_o.wrap |=> async_scan_o.slot == SLOT_FIRST;
  endproperty
  a_as_wrap: assert property (p_as_wrap) else $error("no wrap to slot zero");
  property p_restart; scan_restart_i |=> iso_scan_o.slot == SLOT_FIRST
    && int_scan_o.slot == SLOT_FIRST && async_scan_o.slot == SLOT_FIRST; endproperty
  a_restart: assert property (p_restart) else $error("restart missed");
  property p_hold; !int_step_i && !scan_restart_i |=> $stable(int_scan_o.slot); endproperty
  a_hold: assert property (p_hold) else $error("slot moved unasked");
  // Main scenarios reached
  c_clear: cover property (rd_int ##2 rd_int);
  c_wrap: cover property (async_step_i && async_scan_o.wrap);
  c_keep: cover property (rd_as && async_done_i != 32'h0);
endmodule // dsm_sched_maps_chk

bind dsm_sched_maps dsm_sched_maps_chk dsm_sched_maps_chk_i (.mclk_i, .rst_n_i, .req_i,
  .rdata_o, .rvalid_o, .int_done_i, .async_done_i, .iso_skip_map_i, .int_step_i,
  .async_step_i, .scan_restart_i, .iso_scan_o, .int_scan_o, .async_scan_o);

// *** tb/dsm_sched_maps_tb_top.sv ***
// Bench for the schedule map bank: registers, completion maps and scanners.
// Drives every port itself; the checker is bound from its own file.
`timescale 1ns/10ps
`define CHK(G, X) begin samples_checked++; if ((G) !== (X)) begin miscompares++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, G, X); end end
module dsm_sched_maps_tb_top
  import dsm_pkg::*;
;
  logic        mclk_i = 1'b0;    // 10 MHz bench clock
  logic        rst_n_i = 1'b0;   // Held low for 16 cycles
  dsm_req_t    req = '0;         // Register request
  logic [31:0] int_done = '0;    // Completion pulses
  logic [31:0] async_done = '0;
  logic [31:0] iso_skip = '0;    // Outside isochronous skip map
  logic [2:0]  steps = '0;       // Step per category: iso, int, async
  logic        restart = 1'b0;
  logic [31:0] rdata;
  logic        rvalid;
  dsm_scan_t   sc [3];           // Scanner answers by category
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  // Every mapped word plus one unmapped word after the bank
  logic [15:0] offs [8] = '{OFF_ISO_FINAL, OFF_INT_DONE, OFF_INT_SKIP, OFF_INT_FINAL,
    OFF_ASYNC_DONE, OFF_ASYNC_SKIP, OFF_ASYNC_FINAL, 16'h015C};
  logic [31:0] rsts [8] = '{RST_FINAL, RST_DONE, RST_SKIP, RST_FINAL, RST_DONE, RST_SKIP,
    RST_FINAL, RD_NONE};
  logic [15:0] fin_off [3] = '{OFF_ISO_FINAL, OFF_INT_FINAL, OFF_ASYNC_FINAL};
  logic [15:0] skp_off [3] = '{16'h0000, OFF_INT_SKIP, OFF_ASYNC_SKIP};
  logic [31:0] fins [6] = '{32'h1, 32'h2, 32'h4, 32'h3, 32'h0, 32'h0};

  dsm_sched_maps dsm_sched_maps_i (.mclk_i, .rst_n_i, .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .int_done_i(int_done), .async_done_i(async_done),
    .iso_skip_map_i(iso_skip), .iso_step_i(steps[0]), .int_step_i(steps[1]),
    .async_step_i(steps[2]), .scan_restart_i(restart), .iso_scan_o(sc[0]),
    .int_scan_o(sc[1]), .async_scan_o(sc[2]));

  always #50 mclk_i = ~mclk_i;

  // Hang guard, well above the roughly 920 cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i); #1 req = '{rd:1'b0, wr:1'b1, addr:a, wdata:d};
    @(posedge mclk_i); #1 req.wr = 1'b0;
  endtask

  // Read with an optional async completion pulse in the strobe cycle
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [31:0] dn = '0);
    @(posedge mclk_i); #1 req = '{rd:1'b1, wr:1'b0, addr:a, wdata:32'h0};
    async_done = dn;
    @(posedge mclk_i); #1 req.rd = 1'b0;
    async_done = 32'h0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, x)
  endtask

  function automatic logic [4:0] nxt(input logic [4:0] s, input logic [31:0] f);
    return (f[s] || s == SLOT_LAST) ? SLOT_FIRST : s + SLOT_ONE;
  endfunction

  // Restart all three scanners, then step one of them every cycle against the model
  task automatic scan(input int c, input logic [31:0] f, input logic [31:0] k);
    logic [4:0] e;
    wr(fin_off[c], f);
    if (c == 0) iso_skip = k;
    else wr(skp_off[c], k);
    @(posedge mclk_i); #1 restart = 1'b1;
    @(posedge mclk_i); #1 restart = 1'b0;
    e = SLOT_FIRST;
    repeat (40) begin
      `CHK(sc[c].slot, e)
      `CHK(sc[c].process, ~k[e])
      `CHK(sc[c].wrap, f[e] || e == SLOT_LAST)
      steps[c] = 1'b1;
      e = nxt(e, f);
      @(posedge mclk_i); #1;
    end
    steps[c] = 1'b0;
  endtask

  initial begin
    logic [31:0] v;
    void'($urandom(32'hD72F64AA));
    repeat (16) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    foreach (offs[i]) rd(offs[i], rsts[i]);
    $display("reset values done");
    // Random writes; completion maps and the hole stay zero
    foreach (offs[i]) begin
      v = $urandom;
      wr(offs[i], v);
      rd(offs[i], (offs[i] == OFF_INT_DONE || offs[i] == OFF_ASYNC_DONE || i == 7) ? '0 : v);
      // Line above
    end
    $display("read write done");
    repeat (4) begin
      v = $urandom;
      @(posedge mclk_i); #1 int_done = v;
      @(posedge mclk_i); #1 int_done = 32'h0;
      rd(OFF_INT_DONE, v);
      rd(OFF_INT_DONE, 32'h0);
      v = $urandom;
      rd(OFF_ASYNC_DONE, 32'h0, v);
      rd(OFF_ASYNC_DONE, v);
    end
    $display("completion maps done");
    fins[5] = $urandom;
    // No descriptor pointers are modelled, so no skip or final bit can break them
    foreach (fins[j]) for (int c = 0; c < 3; c++)
      scan(c, fins[j], $urandom);
    $display("scanners done");
    give_verdict();
  end
endmodule // dsm_sched_maps_tb_top
